// File: shared/lcm_pkg.sv
// Behaviour
// - third-order compensator, three zeros, three poles
// - first pole integrates, unbounded DC gain
// - second pole plus zeros shape mid-band
// - third pole low-passes modulator noise
// - four numerator, three denominator coefficients
// - numerator high/low pairs, single denominator registers
// - shared line equalises paralleled output currents
// - 8-bit converter digitises voltage, current, temperature
// - each quantity sampled at least 1 kHz
// - current reading corrected by measured temperature
// - monitor registers refresh without software request
// - manager copies readable monitor registers
package lcm_pkg;
    // -----------------------------------------------------------------
    // register byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] OFS_NUM_COEF0_HIGH = 8'h00;
    localparam logic [7:0] OFS_NUM_COEF0_LOW = 8'h04;
    localparam logic [7:0] OFS_NUM_COEF1_HIGH = 8'h08;
    localparam logic [7:0] OFS_NUM_COEF1_LOW = 8'h0C;
    localparam logic [7:0] OFS_NUM_COEF2_HIGH = 8'h10;
    localparam logic [7:0] OFS_NUM_COEF2_LOW = 8'h14;
    localparam logic [7:0] OFS_NUM_COEF3_HIGH = 8'h18;
    localparam logic [7:0] OFS_NUM_COEF3_LOW = 8'h1C;
    localparam logic [7:0] OFS_DEN_COEF_FIRST = 8'h20;
    localparam logic [7:0] OFS_DEN_COEF_SECOND = 8'h24;
    localparam logic [7:0] OFS_DEN_COEF_THIRD = 8'h28;
    localparam logic [7:0] OFS_VOUT_MONITOR = 8'h2C;
    localparam logic [7:0] OFS_IOUT_MONITOR = 8'h30;
    localparam logic [7:0] OFS_TEMP_MONITOR = 8'h34;
    localparam logic [7:0] OFS_CTRL = 8'h38;
    localparam logic [7:0] OFS_DUTY = 8'h3C;
    // -----------------------------------------------------------------
    // fields, reset values
    // -----------------------------------------------------------------
    localparam int CTRL_FILT_EN = 0;
    localparam int CTRL_SHARE_EN = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [7:0] COEF_BYTE_RESET = 8'h00;
    localparam logic [15:0] DEN_RESET = 16'h0000;
    localparam int COEF_FRAC = 12;
    localparam logic signed [9:0] TEMP_REF = 10'sh040;
    localparam int SHARE_SHIFT = 2;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_US * 1000 / CLK_NS;

    typedef enum logic [1:0] {CH_VOUT, CH_IOUT, CH_TEMP} lcm_chan_t;

    typedef struct packed {
        logic [7:0] vout;
        logic [7:0] iout;
        logic [7:0] temp;
    } lcm_mon_t;
endpackage : lcm_pkg

// File: core/lcm_top.sv
`timescale 1ns/1ps
`default_nettype none
module lcm_top
    import lcm_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_PERIOD_CYC
)(
    // clock, reset
    input wire logic mclk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // control loop
    input wire logic sw_tick,
    input wire logic signed [8:0] err_sample,
    output logic [7:0] duty,
    output logic duty_valid,
    // monitor converter
    output logic adc_start,
    output logic [1:0] adc_sel,
    input wire logic adc_done,
    input wire logic [7:0] adc_data,
    // current share line
    input wire logic cs_in,
    output logic cs_out,
    output logic cs_oe
);
    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [9:0] pin_meta_reg, pin_sync_reg;
    always_ff @(posedge mclk)
    begin
        pin_meta_reg <= {cs_in, adc_done, adc_data};
        pin_sync_reg <= pin_meta_reg;
    end
    wire logic done_s = pin_sync_reg[8];
    wire logic cs_s = pin_sync_reg[9];
    wire logic [7:0] data_s = pin_sync_reg[7:0];

    // -----------------------------------------------------------------
    // register file and bus slave
    // -----------------------------------------------------------------
    logic [7:0] num_hi_reg [4], num_hi_next [4];
    logic [7:0] num_lo_reg [4], num_lo_next [4];
    logic [15:0] den_reg [3], den_next [3];
    logic [1:0] ctrl_reg, ctrl_next;
    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    lcm_mon_t mon_reg, mon_next;
    logic [7:0] duty_reg, duty_next;

    wire logic req = read | write;
    wire logic commit_wr = write & ~wait_reg;
    wire logic [7:0] word_adr = {address[7:2], 2'b00};

    always_comb
    begin
        num_hi_next = num_hi_reg;
        num_lo_next = num_lo_reg;
        den_next = den_reg;
        ctrl_next = ctrl_reg;
        wait_next = ~(req & wait_reg);
        rdata_next = rdata_reg;
        if (req & wait_reg)
        begin
            rdata_next = 32'h0000_0000;
            for (int k = 0; k < 4; k++)
            begin
                if (word_adr == OFS_NUM_COEF0_HIGH + 8'(8 * k))
                    rdata_next = {24'h000000, num_hi_reg[k]};
                if (word_adr == OFS_NUM_COEF0_LOW + 8'(8 * k))
                    rdata_next = {24'h000000, num_lo_reg[k]};
            end
            for (int k = 0; k < 3; k++)
                if (word_adr == OFS_DEN_COEF_FIRST + 8'(4 * k))
                    rdata_next = {16'h0000, den_reg[k]};
            unique case (word_adr)
                OFS_VOUT_MONITOR: rdata_next = {24'h000000, mon_reg.vout};
                OFS_IOUT_MONITOR: rdata_next = {24'h000000, mon_reg.iout};
                OFS_TEMP_MONITOR: rdata_next = {24'h000000, mon_reg.temp};
                OFS_CTRL: rdata_next = {30'h00000000, ctrl_reg};
                OFS_DUTY: rdata_next = {24'h000000, duty_reg};
                default: ;
            endcase
        end
        if (commit_wr)
        begin
            // coefficient pairs and single denominator words
            for (int k = 0; k < 4; k++)
            begin
                if (word_adr == OFS_NUM_COEF0_HIGH + 8'(8 * k) && byteenable[0])
                    num_hi_next[k] = writedata[7:0];
                if (word_adr == OFS_NUM_COEF0_LOW + 8'(8 * k) && byteenable[0])
                    num_lo_next[k] = writedata[7:0];
            end
            for (int k = 0; k < 3; k++)
                if (word_adr == OFS_DEN_COEF_FIRST + 8'(4 * k))
                begin
                    if (byteenable[0])
                        den_next[k][7:0] = writedata[7:0];
                    if (byteenable[1])
                        den_next[k][15:8] = writedata[15:8];
                end
            if (word_adr == OFS_CTRL && byteenable[0])
                ctrl_next = writedata[1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            for (int k = 0; k < 4; k++)
            begin
                num_hi_reg[k] <= COEF_BYTE_RESET;
                num_lo_reg[k] <= COEF_BYTE_RESET;
            end
            for (int k = 0; k < 3; k++)
                den_reg[k] <= DEN_RESET;
            ctrl_reg <= CTRL_RESET;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            num_hi_reg <= num_hi_next;
            num_lo_reg <= num_lo_next;
            den_reg <= den_next;
            ctrl_reg <= ctrl_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    // -----------------------------------------------------------------
    // monitor sequencer
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {MON_WAIT, MON_CONV, MON_RELEASE} lcm_mon_state_t;
    lcm_mon_state_t mst_reg, mst_next;
    lcm_chan_t ch_reg, ch_next;
    logic [31:0] per_reg, per_next;
    logic start_reg, start_next;
    logic [17:0] icorr;
    logic [7:0] icorr_sat;

    // inductor resistance grows with temperature, so scale raw current
    always_comb
    begin
        icorr = 18'($signed({1'b0, data_s}) *
            ($signed(10'sh100) + $signed({2'b00, mon_reg.temp}) - TEMP_REF));
        icorr_sat = icorr[17] ? 8'h00 : (|icorr[16:16] ? 8'hFF : icorr[15:8]);
    end

    always_comb
    begin
        mst_next = mst_reg;
        ch_next = ch_reg;
        start_next = start_reg;
        mon_next = mon_reg;
        per_next = (per_reg == 32'(SAMPLE_CYC - 1)) ? 32'h0000_0000 : per_reg + 32'h1;
        unique case (mst_reg)
            MON_WAIT:
                if (per_reg == 32'h0000_0000)
                begin
                    mst_next = MON_CONV;
                    ch_next = CH_VOUT;
                    start_next = 1'b1;
                end
            MON_CONV:
                if (done_s)
                begin
                    start_next = 1'b0;
                    mst_next = MON_RELEASE;
                    unique case (ch_reg)
                        CH_VOUT: mon_next.vout = data_s;
                        CH_IOUT: mon_next.iout = icorr_sat;
                        default: mon_next.temp = data_s;
                    endcase
                end
            MON_RELEASE:
                if (!done_s)
                begin
                    if (ch_reg == CH_TEMP)
                        mst_next = MON_WAIT;
                    else
                    begin
                        ch_next = lcm_chan_t'(ch_reg + 2'd1);
                        start_next = 1'b1;
                        mst_next = MON_CONV;
                    end
                end
            default: mst_next = MON_WAIT;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mst_reg <= MON_WAIT;
            ch_reg <= CH_VOUT;
            start_reg <= 1'b0;
            mon_reg <= '0;
            per_reg <= 32'h0000_0000;
        end
        else
        begin
            mst_reg <= mst_next;
            ch_reg <= ch_next;
            start_reg <= start_next;
            mon_reg <= mon_next;
            per_reg <= per_next;
        end
    end

    // -----------------------------------------------------------------
    // current share line
    // -----------------------------------------------------------------
    // each unit pulls the line low for a time set by its own current;
    // the wired low time is the largest current among paralleled units
    logic [7:0] frame_reg, frame_next, low_reg, low_next, max_reg, max_next;
    logic oe_reg, oe_next;
    always_comb
    begin
        frame_next = frame_reg + 8'h01;
        oe_next = ctrl_reg[CTRL_SHARE_EN] && (frame_reg < mon_reg.iout);
        low_next = (frame_reg == 8'hFF) ? 8'h00 : low_reg + {7'h00, ~cs_s};
        max_next = (frame_reg == 8'hFF) ? low_reg : max_reg;
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            frame_reg <= 8'h00;
            low_reg <= 8'h00;
            max_reg <= 8'h00;
            oe_reg <= 1'b0;
        end
        else
        begin
            frame_reg <= frame_next;
            low_reg <= low_next;
            max_reg <= max_next;
            oe_reg <= oe_next;
        end
    end

    // -----------------------------------------------------------------
    // compensation filter
    // -----------------------------------------------------------------
    // direct form: y = c0 e0 + c1 e1 + c2 e2 + c3 e3 - b1 y1 - b2 y2 - b3 y3;
    // an integrator pole, a mid-band pole and a noise pole come from b1..b3
    logic signed [8:0] e_hist_reg [4], e_hist_next [4];
    logic signed [15:0] y_hist_reg [3], y_hist_next [3];
    logic signed [24:0] tap [7];
    logic signed [35:0] acc;
    logic signed [23:0] y_shift;
    logic signed [15:0] y_new;
    logic signed [16:0] d_sum;
    logic valid_reg, valid_next;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_num
            assign tap[g] = 25'($signed({num_hi_reg[g], num_lo_reg[g]}) *
                (g == 0 ? err_sample : e_hist_reg[g]));
        end
        for (g = 0; g < 3; g++)
        begin : g_den
            assign tap[4 + g] = 25'(-($signed({den_reg[g][15], den_reg[g]}) *
                $signed(y_hist_reg[g][15:7])));
        end
    endgenerate

    always_comb
    begin
        acc = 36'sd0;
        for (int k = 0; k < 7; k++)
            acc = acc + 36'(tap[k]);
        y_shift = 24'(acc >>> (COEF_FRAC - 7));
        if (y_shift > 24'sh007FFF)
            y_new = 16'sh7FFF;
        else if (y_shift < -24'sh008000)
            y_new = -16'sh8000;
        else
            y_new = y_shift[15:0];
        d_sum = 17'(y_new >>> 7) + (ctrl_reg[CTRL_SHARE_EN] ?
            17'($signed({1'b0, max_reg}) - $signed({1'b0, mon_reg.iout})) >>> SHARE_SHIFT
            : 17'sd0);
        e_hist_next = e_hist_reg;
        y_hist_next = y_hist_reg;
        duty_next = duty_reg;
        valid_next = 1'b0;
        if (!ctrl_reg[CTRL_FILT_EN])
        begin
            for (int k = 0; k < 4; k++)
                e_hist_next[k] = 9'sd0;
            for (int k = 0; k < 3; k++)
                y_hist_next[k] = 16'sd0;
            duty_next = 8'h00;
        end
        else if (sw_tick)
        begin
            e_hist_next[1] = err_sample;
            e_hist_next[2] = e_hist_reg[1];
            e_hist_next[3] = e_hist_reg[2];
            y_hist_next[0] = y_new;
            y_hist_next[1] = y_hist_reg[0];
            y_hist_next[2] = y_hist_reg[1];
            duty_next = d_sum < 0 ? 8'h00 : (d_sum > 17'sd255 ? 8'hFF : d_sum[7:0]);
            valid_next = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            for (int k = 0; k < 4; k++)
                e_hist_reg[k] <= 9'sd0;
            for (int k = 0; k < 3; k++)
                y_hist_reg[k] <= 16'sd0;
            duty_reg <= 8'h00;
            valid_reg <= 1'b0;
        end
        else
        begin
            e_hist_reg <= e_hist_next;
            y_hist_reg <= y_hist_next;
            duty_reg <= duty_next;
            valid_reg <= valid_next;
        end
    end

    assign readdata = rdata_reg;
    assign waitrequest = wait_reg;
    assign duty = duty_reg;
    assign duty_valid = valid_reg;
    assign adc_start = start_reg;
    assign adc_sel = ch_reg;
    assign cs_out = 1'b0;
    assign cs_oe = oe_reg;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    AST_TICK_OUT: assert property (@(posedge mclk) disable iff (reset)
        ctrl_reg[CTRL_FILT_EN] && sw_tick |=> duty_valid && duty == $past(duty_next))
        else $error("filter output missing after switching tick");
    AST_NO_TICK: assert property (@(posedge mclk) disable iff (reset)
        !sw_tick ##1 ctrl_reg[CTRL_FILT_EN] |-> !duty_valid && $stable(duty))
        else $error("filter output changed without tick");
    AST_FILT_OFF: assert property (@(posedge mclk) disable iff (reset)
        !ctrl_reg[CTRL_FILT_EN] |=> duty == 8'h00 && y_hist_reg[0] == 16'sd0)
        else $error("disabled filter did not clear");
    AST_COEF_WR: assert property (@(posedge mclk) disable iff (reset)
        commit_wr && word_adr == OFS_NUM_COEF0_HIGH && byteenable[0]
        |=> num_hi_reg[0] == $past(writedata[7:0]))
        else $error("numerator high byte not stored");
    AST_DEN_WR: assert property (@(posedge mclk) disable iff (reset)
        commit_wr && word_adr == OFS_DEN_COEF_THIRD && byteenable[1:0] == 2'b11
        |=> den_reg[2] == $past(writedata[15:0]))
        else $error("denominator word not stored");
    AST_ADC_REL: assert property (@(posedge mclk) disable iff (reset)
        mst_reg == MON_CONV && done_s |=> !adc_start ##1 mst_reg == MON_RELEASE)
        else $error("converter start not released");
    AST_SWEEP: assert property (@(posedge mclk) disable iff (reset)
        mst_reg == MON_WAIT && per_reg == 32'h0 |=> adc_start && adc_sel == CH_VOUT)
        else $error("sample sweep did not start on period");
    AST_ICORR: assert property (@(posedge mclk) disable iff (reset)
        mst_reg == MON_CONV && done_s && ch_reg == CH_IOUT
        && $signed({2'b00, mon_reg.temp}) == TEMP_REF |=> mon_reg.iout == $past(data_s))
        else $error("current not equal raw at reference temperature");
    AST_RD_MON: assert property (@(posedge mclk) disable iff (reset)
        read && wait_reg && word_adr == OFS_VOUT_MONITOR
        |=> !waitrequest && readdata == {24'h0, $past(mon_reg.vout)})
        else $error("monitor read returned wrong data");
    AST_SHARE: assert property (@(posedge mclk) disable iff (reset)
        frame_reg == 8'hFF |=> max_reg == $past(low_reg) && low_reg == 8'h00)
        else $error("share frame capture wrong");
endmodule : lcm_top
`default_nettype wire

// File: verification/lcm_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcm_adc_model
    import lcm_pkg::*;
#(
    parameter int SLOW = 17
)(
    // clock, reset
    input wire logic mclk,
    input wire logic reset,
    // converter handshake
    input wire logic adc_start,
    input wire logic [1:0] adc_sel,
    output logic adc_done,
    output logic [7:0] adc_data,
    // values to convert
    input wire lcm_mon_t mon
);
    int cnt;
    logic slow;

    // alternates prompt and slow conversions; data toggles while not valid
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cnt <= 0;
            slow <= 1'b0;
            adc_done <= 1'b0;
            adc_data <= 8'h5A;
        end
        else if (adc_start && !adc_done)
        begin
            if (cnt >= (slow ? SLOW : 1))
            begin
                adc_done <= 1'b1;
                adc_data <= (adc_sel == 2'h0) ? mon.vout : (adc_sel == 2'h1) ? mon.iout : mon.temp;
                cnt <= 0;
                slow <= !slow;
            end
            else
            begin
                cnt <= cnt + 1;
                adc_data <= ~adc_data;
            end
        end
        else if (!adc_start && adc_done)
        begin
            adc_done <= 1'b0;
            adc_data <= ~adc_data;
        end
        else if (!adc_done)
        begin
            adc_data <= ~adc_data;
        end
    end
endmodule : lcm_adc_model
`default_nettype wire

// File: verification/lcm_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lcm_top_bench
    import lcm_pkg::*;
;
    localparam int SCYC = 200;
    logic mclk, reset, read, write, sw_tick, waitrequest, duty_valid, adc_start, adc_done;
    logic cs_out, cs_oe, st_q;
    wire logic cs_in;
    logic [7:0] address, duty, adc_data;
    logic [31:0] writedata, readdata, seed, rd;
    logic [3:0] byteenable;
    logic signed [8:0] err_sample;
    logic [1:0] adc_sel;
    lcm_mon_t mon;
    logic [15:0] rv [11];
    int n_mismatch, samples_checked, cyc, sweeps, dlast, k, n0, iexp, cnt;
    longint cf [4], dn [4], eh [4], yh [4];

    lcm_top #(.SAMPLE_CYC(SCYC)) u_dut (.mclk(mclk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .sw_tick(sw_tick),
        .err_sample(err_sample), .duty(duty), .duty_valid(duty_valid), .adc_start(adc_start),
        .adc_sel(adc_sel), .adc_done(adc_done), .adc_data(adc_data), .cs_in(cs_in),
        .cs_out(cs_out), .cs_oe(cs_oe));
    lcm_adc_model #(.SLOW(17)) u_adc (.mclk(mclk), .reset(reset), .adc_start(adc_start),
        .adc_sel(adc_sel), .adc_done(adc_done), .adc_data(adc_data), .mon(mon));
    // open-drain share line with pull-up; a paralleled peer set up with a
    // small droop pulls it low for raw current less 1/16, not temperature corrected
    logic [7:0] peer_cnt = 8'h00;
    logic peer_low = 1'b0;
    assign cs_in = !(cs_oe || peer_low);

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        address <= a;
        writedata <= wd;
        write <= wr;
        read <= !wr;
        do
        begin
            @(posedge mclk);
        end
        while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic chkr(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : chkr

    // model: y = (sum c e - sum b (y>>7)) >> (frac-7), sat16; duty = clamp(y>>7)
    function automatic int filt(longint e);
        longint acc;
        longint y;
        acc = cf[0] * e;
        for (int i = 1; i < 4; i++)
            acc += cf[i] * eh[i] - dn[i] * (yh[i] >>> 7);
        y = acc >>> (COEF_FRAC - 7);
        y = (y > 32767) ? 32767 : (y < -32768) ? -32768 : y;
        for (int i = 3; i > 1; i--)
        begin
            eh[i] = eh[i - 1];
            yh[i] = yh[i - 1];
        end
        eh[1] = e;
        yh[1] = y;
        y = y >>> 7;
        return int'((y > 255) ? 255 : (y < 0) ? 0 : y);
    endfunction : filt

    task automatic load_coefs(input logic rand_set);
        logic [31:0] v;
        for (int i = 0; i < 11; i++)
        begin
            v = rand_set ? ((i < 8) ? rnd() : (rnd() & 32'h0FFF) - 32'h0800) :
                ((i == 0) ? 32'h10 : (i == 8) ? 32'hF000 : 32'h0);
            bus(1'b1, 8'(i * 4), v);
            rv[i] = v[15:0];
            chkr(8'(i * 4), (i < 8) ? (v & 32'hFF) : (v & 32'hFFFF));
        end
        for (int i = 0; i < 4; i++)
            cf[i] = longint'($signed({rv[2 * i][7:0], rv[2 * i + 1][7:0]}));
        for (int i = 1; i < 4; i++)
            dn[i] = longint'($signed(rv[7 + i]));
        eh = '{default: 0};
        yh = '{default: 0};
    endtask : load_coefs

    task automatic run_filt(input int n, input logic en, input logic pos);
        logic t1, t2, tk;
        int d1, d2;
        logic [31:0] r;
        t1 = 1'b0;
        t2 = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            @(posedge mclk);
            if (t2)
                dlast = d2;
            chk(32'(duty_valid), 32'(t2));
            chk(32'(duty), dlast);
            t2 = t1;
            d2 = d1;
            r = rnd();
            tk = (r[0] | r[1]) && (i < n - 2);
            sw_tick <= tk;
            err_sample <= pos ? {1'b0, r[15:8]} : r[16:8];
            t1 = tk & en;
            if (t1)
                d1 = filt(pos ? longint'(r[15:8]) : longint'($signed(r[16:8])));
        end
    endtask : run_filt

    // -----------------------------------------------------------------
    // timeout and sweep counter
    // -----------------------------------------------------------------
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        st_q <= adc_start;
        peer_cnt <= peer_cnt + 8'h01;
        peer_low <= peer_cnt < mon.iout - (mon.iout >> 4);
        if (st_q && !adc_start && adc_sel == 2'h2)
            sweeps <= sweeps + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial
    begin
        {read, write, sw_tick, st_q} = 4'h0;
        reset = 1'b1;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'hF;
        err_sample = 9'h000;
        mon = '0;
        seed = 32'h000123ED;
        {n_mismatch, samples_checked, cyc, sweeps, dlast} = '0;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk(32'(waitrequest), 32'h1);
        chk(32'(duty), 32'h0);
        for (int i = 0; i < 11; i++)
            chkr(8'(i * 4), 32'h0);
        chkr(OFS_CTRL, 32'h3);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        chkr(8'h40, 32'h0);
        byteenable <= 4'h1;
        bus(1'b1, OFS_DEN_COEF_SECOND, 32'hABCD);
        byteenable <= 4'hF;
        chkr(OFS_DEN_COEF_SECOND, 32'h00CD);
        for (int s = 0; s < 4; s++)
        begin
            mon <= (s == 0) ? lcm_mon_t'(24'(rnd())) : (s == 1) ? 24'hFFFFFF :
                (s == 2) ? 24'h37C800 : 24'h37C840;
            @(posedge mclk);
            n0 = sweeps;
            k = 0;
            while (sweeps < n0 + 3 && k < 4 * SCYC)
            begin
                @(posedge mclk);
                k++;
            end
            chk(32'(k < 4 * SCYC), 32'h1);
            chkr(OFS_VOUT_MONITOR, 32'(mon.vout));
            chkr(OFS_TEMP_MONITOR, 32'(mon.temp));
            iexp = (int'(mon.iout) * (192 + int'(mon.temp))) >> 8;
            iexp = (iexp > 255) ? 255 : iexp;
            chkr(OFS_IOUT_MONITOR, iexp);
            cnt = 0;
            repeat (256)
            begin
                @(posedge mclk);
                cnt += int'(cs_oe);
            end
            chk(cnt, iexp);
            chk(32'(cs_out), 32'h0);
        end
        bus(1'b1, OFS_CTRL, 32'h1);
        load_coefs(1'b1);
        run_filt(60, 1'b1, 1'b0);
        bus(1'b1, OFS_CTRL, 32'h0);
        dlast = 0;
        // the cleared duty shows one cycle after the control write lands
        @(posedge mclk);
        run_filt(20, 1'b0, 1'b0);
        load_coefs(1'b0);
        bus(1'b1, OFS_CTRL, 32'h1);
        run_filt(120, 1'b1, 1'b1);
        chkr(OFS_DUTY, dlast);
        tally_and_finish();
    end
endmodule : lcm_top_bench
`default_nettype wire
